// >>> verilog/spbram_top.sv
// Top: single-port block memory with its AXI4-Lite configuration slave
//
// Overview of operation
// - Enable low at an edge: no write, no read, no set/reset.
// - Disabled edge keeps memory and output latches, output unchanged.
// - Enabled edge, write enable and set/reset low: memory kept, addressed word appears on output.
// - Enabled edge, write enable high, set/reset low: addressed word replaced by write data.
// - Write-through mode: written word also appears on the output.
// - Set/reset at enabled edge loads the output reset value into the latches.
// - Set/reset never alters memory and ignores address and write data.
// - Read-before-write and output-hold modes also selectable, same timing.
//
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
module spbram_top #(
  parameter int ADDR_W = 10,
  parameter int DATA_W = 16
) (
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic              enable,
  input  wire logic              writeEnable,
  input  wire logic              syncOutputReset,
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic [DATA_W-1:0] writeDataIn,
  output logic      [DATA_W-1:0] dataOut,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic      [1:0]        s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic      [31:0]       s_axi_rdata,
  output logic      [1:0]        s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  // ----------------------------------------------------------------
  // Types and functions
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                     awHave;
    logic [7:0]               awAddr;
    logic                     wHave;
    logic [31:0]              wData;
    logic [3:0]               wStrb;
    logic                     bValid;
    logic [1:0]               bResp;
    logic                     rValid;
    logic [31:0]              rData;
    logic [1:0]               rResp;
    spbram_pkg::spbram_mode_t mode;
    logic                     portGate;
    logic [31:0]              rstVal;
    spbram_pkg::spbram_op_t   lastOp;
    logic [31:0]              wrCount;
    logic [31:0]              rdCount;
    logic [31:0]              ssrCount;
  } spbram_top_state_t;

  // Byte-lane merge for register writes
  function automatic logic [31:0] mergeStrb(
    input logic [31:0] oldVal,
    input logic [31:0] newVal,
    input logic [3:0]  strb
  );
    logic [31:0] res;
    res = oldVal;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = newVal[8*i +: 8];
      end
    end
    return res;
  endfunction : mergeStrb

  // Event counter; an event in the clearing cycle still counts
  function automatic logic [31:0] bumpCount(
    input logic [31:0] cnt,
    input logic        inc,
    input logic        clr
  );
    logic [31:0] res;
    res = clr ? spbram_pkg::COUNT_RST : cnt;
    if (inc) begin
      res = res + 32'h1;
    end
    return res;
  endfunction : bumpCount

  // Address decode shared by both channels
  function automatic logic isMapped(input logic [7:0] addr);
    logic hit;
    hit = 1'b0;
    if (addr == spbram_pkg::OFS_CTRL) begin
      hit = 1'b1;
    end else if (addr == spbram_pkg::OFS_RSTVAL) begin
      hit = 1'b1;
    end else if (addr == spbram_pkg::OFS_STATUS) begin
      hit = 1'b1;
    end else if (addr == spbram_pkg::OFS_WRCOUNT) begin
      hit = 1'b1;
    end else if (addr == spbram_pkg::OFS_RDCOUNT) begin
      hit = 1'b1;
    end else if (addr == spbram_pkg::OFS_SSRCOUNT) begin
      hit = 1'b1;
    end
    return hit;
  endfunction : isMapped

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rstMeta_reg;
  logic rstSync_n;

  // Assert at once, release after two edges
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_reg <= 1'b0;
      rstSync_n   <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstSync_n   <= rstMeta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Memory core
  // ----------------------------------------------------------------
  spbram_mem_if #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) memBus ();

  spbram_top_state_t state_reg;
  spbram_top_state_t state_next;

  // Port inputs come from fabric on this clock: no synchronisers
  assign memBus.enable           = enable & state_reg.portGate;
  assign memBus.writeEnable      = writeEnable;
  assign memBus.syncOutputReset  = syncOutputReset;
  assign memBus.address          = address;
  assign memBus.writeDataIn      = writeDataIn;
  assign memBus.mode             = state_reg.mode;
  assign memBus.outputResetValue = state_reg.rstVal[DATA_W-1:0];

  spbram_core #(
    .ADDR_W (ADDR_W),
    .DATA_W (DATA_W)
  ) core (
    .clk_sys   (clk_sys),
    .rstSync_n (rstSync_n),
    .mem       (memBus)
  );

  assign dataOut = memBus.dataOut;

  // ----------------------------------------------------------------
  // Bus handshakes
  // ----------------------------------------------------------------
  logic awFire;
  logic wFire;
  logic arFire;
  logic doRegWrite;
  logic [7:0]  wrAddr;
  logic [31:0] wrData;
  logic [3:0]  wrStrb;

  // A new write is held off until the previous answer is taken
  assign s_axi_awready = !state_reg.awHave && !state_reg.bValid;
  assign s_axi_wready  = !state_reg.wHave && !state_reg.bValid;
  assign s_axi_arready = !state_reg.rValid;
  assign awFire        = s_axi_awvalid && s_axi_awready;
  assign wFire         = s_axi_wvalid && s_axi_wready;
  assign arFire        = s_axi_arvalid && s_axi_arready;
  assign wrAddr        = state_reg.awHave ? state_reg.awAddr : s_axi_awaddr;
  assign wrData        = state_reg.wHave ? state_reg.wData : s_axi_wdata;
  assign wrStrb        = state_reg.wHave ? state_reg.wStrb : s_axi_wstrb;
  assign doRegWrite    = (state_reg.awHave || awFire) && (state_reg.wHave || wFire);

  assign s_axi_bvalid  = state_reg.bValid;
  assign s_axi_bresp   = state_reg.bResp;
  assign s_axi_rvalid  = state_reg.rValid;
  assign s_axi_rdata   = state_reg.rData;
  assign s_axi_rresp   = state_reg.rResp;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic clrWr;
  logic clrRd;
  logic clrSsr;

  always_comb begin
    state_next = state_reg;
    clrWr      = 1'b0;
    clrRd      = 1'b0;
    clrSsr     = 1'b0;

    // Write channel capture, either order
    if (awFire) begin
      state_next.awHave = 1'b1;
      state_next.awAddr = s_axi_awaddr;
    end
    if (wFire) begin
      state_next.wHave = 1'b1;
      state_next.wData = s_axi_wdata;
      state_next.wStrb = s_axi_wstrb;
    end

    if (doRegWrite) begin
      state_next.awHave = 1'b0;
      state_next.wHave  = 1'b0;
      state_next.bValid = 1'b1;
      state_next.bResp  = isMapped(wrAddr) ? spbram_pkg::RESP_OKAY : spbram_pkg::RESP_SLVERR;
      if (wrAddr == spbram_pkg::OFS_CTRL) begin
        if (wrStrb[0]) begin
          state_next.mode = spbram_pkg::spbram_mode_t'(wrData[spbram_pkg::CTRL_MODE_LSB +: 2]);
        end
        if (wrStrb[1]) begin
          state_next.portGate = wrData[spbram_pkg::CTRL_GATE_BIT];
        end
      end else if (wrAddr == spbram_pkg::OFS_RSTVAL) begin
        state_next.rstVal = mergeStrb(state_reg.rstVal, wrData, wrStrb);
      end else if (wrAddr == spbram_pkg::OFS_WRCOUNT) begin
        clrWr = 1'b1;
      end else if (wrAddr == spbram_pkg::OFS_RDCOUNT) begin
        clrRd = 1'b1;
      end else if (wrAddr == spbram_pkg::OFS_SSRCOUNT) begin
        clrSsr = 1'b1;
      end
    end else if (state_reg.bValid && s_axi_bready) begin
      state_next.bValid = 1'b0;
    end

    // Read channel: answer one cycle after the address is taken
    if (arFire) begin
      state_next.rValid = 1'b1;
      state_next.rResp  = isMapped(s_axi_araddr) ? spbram_pkg::RESP_OKAY : spbram_pkg::RESP_SLVERR;
      state_next.rData  = 32'h0;
      if (s_axi_araddr == spbram_pkg::OFS_CTRL) begin
        state_next.rData[spbram_pkg::CTRL_MODE_LSB +: 2] = state_reg.mode;
        state_next.rData[spbram_pkg::CTRL_GATE_BIT]      = state_reg.portGate;
      end else if (s_axi_araddr == spbram_pkg::OFS_RSTVAL) begin
        state_next.rData = state_reg.rstVal;
      end else if (s_axi_araddr == spbram_pkg::OFS_STATUS) begin
        state_next.rData[spbram_pkg::STAT_OP_LSB +: 2] = state_reg.lastOp;
      end else if (s_axi_araddr == spbram_pkg::OFS_WRCOUNT) begin
        state_next.rData = state_reg.wrCount;
      end else if (s_axi_araddr == spbram_pkg::OFS_RDCOUNT) begin
        state_next.rData = state_reg.rdCount;
      end else if (s_axi_araddr == spbram_pkg::OFS_SSRCOUNT) begin
        state_next.rData = state_reg.ssrCount;
      end
    end else if (state_reg.rValid && s_axi_rready) begin
      state_next.rValid = 1'b0;
    end

    // Activity seen by the memory core
    if (memBus.opCode != spbram_pkg::SPBRAM_OP_IDLE) begin
      state_next.lastOp = memBus.opCode;
    end
    state_next.wrCount  = bumpCount(state_reg.wrCount,
                                    memBus.opCode == spbram_pkg::SPBRAM_OP_WRITE, clrWr);
    state_next.rdCount  = bumpCount(state_reg.rdCount,
                                    memBus.opCode == spbram_pkg::SPBRAM_OP_READ, clrRd);
    state_next.ssrCount = bumpCount(state_reg.ssrCount,
                                    memBus.opCode == spbram_pkg::SPBRAM_OP_SSR, clrSsr);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      state_reg.awHave   <= 1'b0;
      state_reg.awAddr   <= 8'h00;
      state_reg.wHave    <= 1'b0;
      state_reg.wData    <= 32'h0;
      state_reg.wStrb    <= 4'h0;
      state_reg.bValid   <= 1'b0;
      state_reg.bResp    <= spbram_pkg::RESP_OKAY;
      state_reg.rValid   <= 1'b0;
      state_reg.rData    <= 32'h0;
      state_reg.rResp    <= spbram_pkg::RESP_OKAY;
      state_reg.mode     <= spbram_pkg::spbram_mode_t'(spbram_pkg::CTRL_MODE_RST);
      state_reg.portGate <= spbram_pkg::CTRL_GATE_RST;
      state_reg.rstVal   <= spbram_pkg::RSTVAL_RST;
      state_reg.lastOp   <= spbram_pkg::SPBRAM_OP_IDLE;
      state_reg.wrCount  <= spbram_pkg::COUNT_RST;
      state_reg.rdCount  <= spbram_pkg::COUNT_RST;
      state_reg.ssrCount <= spbram_pkg::COUNT_RST;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule : spbram_top

// >>> verilog/spbram_pkg.sv
// Package: constants, register map and types of the single-port block memory
package spbram_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int          AXI_AW         = 8;
  localparam logic [7:0]  OFS_CTRL       = 8'h00;
  localparam logic [7:0]  OFS_RSTVAL     = 8'h04;
  localparam logic [7:0]  OFS_STATUS     = 8'h08;
  localparam logic [7:0]  OFS_WRCOUNT    = 8'h0C;
  localparam logic [7:0]  OFS_RDCOUNT    = 8'h10;
  localparam logic [7:0]  OFS_SSRCOUNT   = 8'h14;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          CTRL_MODE_LSB  = 0;
  localparam int          CTRL_GATE_BIT  = 8;
  localparam int          STAT_OP_LSB    = 0;
  localparam logic [1:0]  CTRL_MODE_RST  = 2'h0;
  localparam logic        CTRL_GATE_RST  = 1'b1;
  localparam logic [31:0] RSTVAL_RST     = 32'h0;
  localparam logic [31:0] COUNT_RST      = 32'h0;
  localparam logic [31:0] DOUT_RST       = 32'h0;

  // ----------------------------------------------------------------
  // Bus answers
  // ----------------------------------------------------------------
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SPBRAM_WRITE_THROUGH = 2'h0,
    SPBRAM_READ_BEFORE   = 2'h1,
    SPBRAM_OUTPUT_HOLD   = 2'h3
  } spbram_mode_t;

  typedef enum logic [1:0] {
    SPBRAM_OP_IDLE  = 2'h0,
    SPBRAM_OP_READ  = 2'h1,
    SPBRAM_OP_WRITE = 2'h3,
    SPBRAM_OP_SSR   = 2'h2
  } spbram_op_t;

  typedef struct packed {
    logic [31:0] dataOut;
  } spbram_core_state_t;

endpackage : spbram_pkg

// >>> verilog/spbram_mem_if.sv
// Interface: signals between the bus-facing top and the memory core
`timescale 1ns/100ps
interface spbram_mem_if #(
  parameter int ADDR_W = 10,
  parameter int DATA_W = 16
);
  logic                     enable;
  logic                     writeEnable;
  logic                     syncOutputReset;
  logic [ADDR_W-1:0]        address;
  logic [DATA_W-1:0]        writeDataIn;
  spbram_pkg::spbram_mode_t mode;
  logic [DATA_W-1:0]        outputResetValue;
  logic [DATA_W-1:0]        dataOut;
  spbram_pkg::spbram_op_t   opCode;

  modport core (
    input  enable,
    input  writeEnable,
    input  syncOutputReset,
    input  address,
    input  writeDataIn,
    input  mode,
    input  outputResetValue,
    output dataOut,
    output opCode
  );

  modport ctrl (
    output enable,
    output writeEnable,
    output syncOutputReset,
    output address,
    output writeDataIn,
    output mode,
    output outputResetValue,
    input  dataOut,
    input  opCode
  );
endinterface : spbram_mem_if

// >>> verilog/spbram_core.sv
// Memory core: storage array and output latches
`timescale 1ns/100ps
module spbram_core #(
  parameter int ADDR_W = 10,
  parameter int DATA_W = 16
) (
  input  wire logic clk_sys,
  input  wire logic rstSync_n,
  spbram_mem_if.core mem
);

  localparam int DEPTH = 1 << ADDR_W;

  logic [DATA_W-1:0]              store [DEPTH];
  spbram_pkg::spbram_core_state_t state_reg;
  spbram_pkg::spbram_core_state_t state_next;
  logic [DATA_W-1:0]              storedWord;
  logic                           doWrite;

  assign storedWord = store[mem.address];
  // Set/reset takes priority so it never alters a stored word
  assign doWrite    = mem.enable && mem.writeEnable && !mem.syncOutputReset;

  // ----------------------------------------------------------------
  // Output latch next value
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    mem.opCode = spbram_pkg::SPBRAM_OP_IDLE;
    if (mem.enable) begin
      if (mem.syncOutputReset) begin
        // Address and data ignored here
        state_next.dataOut = 32'(mem.outputResetValue);
        mem.opCode         = spbram_pkg::SPBRAM_OP_SSR;
      end else if (mem.writeEnable) begin
        mem.opCode = spbram_pkg::SPBRAM_OP_WRITE;
        case (mem.mode)
          spbram_pkg::SPBRAM_READ_BEFORE: begin
            state_next.dataOut = 32'(storedWord);
          end
          spbram_pkg::SPBRAM_OUTPUT_HOLD: begin
            state_next.dataOut = state_reg.dataOut;
          end
          default: begin
            state_next.dataOut = 32'(mem.writeDataIn);
          end
        endcase
      end else begin
        state_next.dataOut = 32'(storedWord);
        mem.opCode         = spbram_pkg::SPBRAM_OP_READ;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      state_reg.dataOut <= spbram_pkg::DOUT_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // No reset on the array: contents survive a bus reset
  always_ff @(posedge clk_sys) begin
    if (doWrite) begin
      store[mem.address] <= mem.writeDataIn;
    end
  end

  assign mem.dataOut = state_reg.dataOut[DATA_W-1:0];

endmodule : spbram_core

// >>> sim/spbram_properties.sv
// Checker: port-level properties of the single-port block memory
`timescale 1ns/100ps
module spbram_properties #(
  parameter int ADDR_W = 10,
  parameter int DATA_W = 16
) (
  input wire logic              clk_sys,
  input wire logic              rst_n,
  input wire logic              enable,
  input wire logic              writeEnable,
  input wire logic              syncOutputReset,
  input wire logic [ADDR_W-1:0] address,
  input wire logic [DATA_W-1:0] writeDataIn,
  input wire logic [DATA_W-1:0] dataOut,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // Port sequences
  // ----------------------------------------------------------------
  sequence wrS;
    enable && writeEnable && !syncOutputReset;
  endsequence
  sequence rdSameS;
    enable && !writeEnable && !syncOutputReset && $stable(address);
  endsequence
  sequence ssrS;
    enable && syncOutputReset;
  endsequence
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  idle_hold_a: assert property (!enable |=> $stable(dataOut))
    else $error("output moved on a disabled edge");
  wr_rd_a: assert property (wrS ##1 rdSameS |=> dataOut == $past(writeDataIn, 2))
    else $error("read after write returned wrong word");
  ssr_repeat_a: assert property (ssrS ##1 ssrS |=> $stable(dataOut))
    else $error("set/reset value depends on address or data");
  aw_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("no write response after address and data");
  b_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not retired");
  ar_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read data after address");
  r_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  r_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data not retired");
endmodule : spbram_properties

bind spbram_top spbram_properties #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_props (
  .clk_sys(clk_sys), .rst_n(rst_n), .enable(enable), .writeEnable(writeEnable),
  .syncOutputReset(syncOutputReset), .address(address), .writeDataIn(writeDataIn), .dataOut(dataOut),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready)
);

// >>> sim/spbram_fabric_model.sv
// Partner: fabric logic driving the memory port
`timescale 1ns/100ps
module spbram_fabric_model #(
  parameter int ADDR_W = 10,
  parameter int DATA_W = 16
) (
  input wire logic        clk_sys,
  output logic              enable,
  output logic              writeEnable,
  output logic              syncOutputReset,
  output logic [ADDR_W-1:0] address,
  output logic [DATA_W-1:0] writeDataIn
);
  initial begin
    enable = 1'b0;
    writeEnable = 1'b0;
    syncOutputReset = 1'b0;
    address = '0;
    writeDataIn = '0;
  end
  // Idle cycles flip address and data so a stale value never looks valid
  task automatic drive(input logic en, input logic we, input logic sync_output_reset,
                       input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    enable <= en;
    writeEnable <= we;
    syncOutputReset <= sync_output_reset;
    address <= (en || we || sync_output_reset) ? a : ~address;
    writeDataIn <= (en || we || sync_output_reset) ? d : ~writeDataIn;
  endtask : drive
endmodule : spbram_fabric_model

// >>> sim/spbram_bench.sv
// Testbench: memory port modes and configuration bus
`timescale 1ns/100ps
module spbram_bench;
  logic        clk_sys, rst_n, enable, writeEnable, syncOutputReset;
  logic [9:0]  address;
  logic [15:0] writeDataIn, dataOut;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int          miscompares, numChecks;

  spbram_fabric_model u_fab (.clk_sys(clk_sys), .enable(enable), .writeEnable(writeEnable),
    .syncOutputReset(syncOutputReset), .address(address), .writeDataIn(writeDataIn));

  spbram_top u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .enable(enable), .writeEnable(writeEnable),
    .syncOutputReset(syncOutputReset), .address(address), .writeDataIn(writeDataIn), .dataOut(dataOut),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));

  // ----------------------------------------------------------------
  // Common tasks
  // ----------------------------------------------------------------
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s: expected %h, seen %h", n, exp, seen);
    end
  endtask : check

  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", numChecks, miscompares);
    if (miscompares == 0 && numChecks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict

  // Readies sampled at the falling edge, which equals their value at the next rising edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic [2:0] s;
    s = 3'h0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    repeat (40) begin
      @(negedge clk_sys);
      s = {s_axi_bvalid === 1'b1, s_axi_awready, s_axi_wready};
      if (s[2]) check("bresp", {30'h0, s_axi_bresp}, {30'h0, r});
      @(posedge clk_sys);
      if (s[2]) break;
      if (s[1]) s_axi_awvalid <= 1'b0;
      if (s[0]) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    if (!s[2]) check("bvalid", 32'h0, 32'h1);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic [1:0] s;
    s = 2'h0;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    repeat (40) begin
      @(negedge clk_sys);
      s = {s_axi_rvalid === 1'b1, s_axi_arready};
      if (s[1]) check("rdata", s_axi_rdata, d);
      if (s[1]) check("rresp", {30'h0, s_axi_rresp}, {30'h0, r});
      @(posedge clk_sys);
      if (s[1]) break;
      if (s[0]) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    if (!s[1]) check("rvalid", 32'h0, 32'h1);
  endtask : axi_rd

  task automatic settle;
    u_fab.drive(1'b0, 1'b0, 1'b0, 10'h000, 16'h0000);
    @(negedge clk_sys);
  endtask : settle

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset;
    check("dout reset", {16'h0, dataOut}, 32'h0);
    axi_rd(spbram_pkg::OFS_CTRL, 32'h0000_0100, spbram_pkg::RESP_OKAY);
    axi_rd(spbram_pkg::OFS_RSTVAL, 32'h0, spbram_pkg::RESP_OKAY);
    axi_wr(spbram_pkg::OFS_RSTVAL, 32'h0000_0101, spbram_pkg::RESP_OKAY);
    axi_rd(spbram_pkg::OFS_RSTVAL, 32'h0000_0101, spbram_pkg::RESP_OKAY);
    axi_wr(8'h40, 32'h0000_0001, spbram_pkg::RESP_SLVERR);
    axi_rd(8'h40, 32'h0, spbram_pkg::RESP_SLVERR);
  endtask : test_reset

  // Set/reset before the second write makes the three modes tell apart
  task automatic test_modes;
    logic [15:0] o, n, e;
    logic [9:0]  a;
    logic [1:0]  m;
    for (int i = 0; i < 3; i++) begin
      m = (i == 2) ? 2'h3 : 2'(i);
      a = 10'h00F + 10'(i);
      o = 16'hAA00 | 16'(i);
      n = 16'hCC00 | 16'(i);
      axi_wr(spbram_pkg::OFS_CTRL, {23'h0, 1'b1, 6'h0, m}, spbram_pkg::RESP_OKAY);
      u_fab.drive(1'b1, 1'b1, 1'b0, a, o);
      u_fab.drive(1'b1, 1'b0, 1'b0, a, 16'h0000);
      settle();
      check("read", {16'h0, dataOut}, {16'h0, o});
      u_fab.drive(1'b1, 1'b1, 1'b1, a, 16'hDEAD);
      u_fab.drive(1'b1, 1'b0, 1'b1, 10'h3FF, 16'hBEEF);
      settle();
      check("setreset", {16'h0, dataOut}, 32'h0000_0101);
      u_fab.drive(1'b1, 1'b1, 1'b0, a, n);
      settle();
      e = (i == 0) ? n : (i == 1) ? o : 16'h0101;
      check("write out", {16'h0, dataOut}, {16'h0, e});
      u_fab.drive(1'b1, 1'b0, 1'b0, a, 16'h0000);
      settle();
      check("stored", {16'h0, dataOut}, {16'h0, n});
    end
  endtask : test_modes

  // Disabled edge carries write and set/reset aimed at a preloaded word
  task automatic test_disable;
    axi_wr(spbram_pkg::OFS_CTRL, 32'h0000_0100, spbram_pkg::RESP_OKAY);
    u_fab.drive(1'b1, 1'b1, 1'b0, 10'h3FE, 16'h1234);
    u_fab.drive(1'b1, 1'b1, 1'b0, 10'h001, 16'h5A5A);
    settle();
    check("through", {16'h0, dataOut}, 32'h0000_5A5A);
    u_fab.drive(1'b0, 1'b1, 1'b0, 10'h3FE, 16'h0000);
    u_fab.drive(1'b0, 1'b0, 1'b1, 10'h3FE, 16'h0000);
    settle();
    check("disabled", {16'h0, dataOut}, 32'h0000_5A5A);
    u_fab.drive(1'b1, 1'b0, 1'b0, 10'h3FE, 16'h0000);
    settle();
    check("untouched", {16'h0, dataOut}, 32'h0000_1234);
  endtask : test_disable

  // ----------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    rst_n = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    miscompares = 0;
    numChecks = 0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    test_reset();
    test_modes();
    test_disable();
    give_verdict();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #50000;
    miscompares++;
    give_verdict();
  end
endmodule : spbram_bench
